// ---- asef_host_model.sv ----
// host-side model driving the serial register port of the flag bank
`timescale 1ns/1ps
module asef_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_wr_taken_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [3:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    // ****************************************
    // register access tasks
    // ****************************************
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 4'h0;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      output logic tk);
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge ref_clk_i);
        // accept flag taken at the edge that samples the write
        tk = reg_wr_taken_i;
        reg_wr_o    <= 1'b0;
        // released data bus shows no stale value
        reg_wdata_o <= ~d;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_i;
    endtask
endmodule // asef_host_model

// ---- asef_new_sample.sv ----
// new-sample flag tracking and data-ready pin drive
`timescale 1ns/1ps
module asef_new_sample
    import asef_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic conv_done_i,
    input  wire logic conv_start_i,
    input  wire logic one_shot_i,
    input  wire logic result_read_i,
    output logic      data_ready_n_o
);
    logic fresh_reg;
    logic fresh_next;

    // ****************************************
    // freshness state
    // ****************************************
    always_comb begin
        fresh_next = fresh_reg;
        if (one_shot_i) begin
            if (conv_start_i) begin
                fresh_next = 1'b0;
            end
        end else if (result_read_i) begin
            fresh_next = 1'b0;
        end
        if (conv_done_i) begin
            fresh_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            fresh_reg <= 1'b0;
        end else begin
            fresh_reg <= fresh_next;
        end
    end

    assign data_ready_n_o = ~fresh_reg;

    hold_one_shot_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        one_shot_i && fresh_reg && !conv_start_i && $stable(one_shot_i)
        |=> fresh_reg)
        else $error("one-shot fresh flag dropped early");
    read_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !one_shot_i && result_read_i && !conv_done_i |=> !fresh_reg)
        else $error("fresh flag not cleared by read");
endmodule // asef_new_sample

// ---- asef_pkg.sv ----
// constants for the status error flag bank
package asef_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_SETUP4     = 4'h8;
    localparam logic [3:0] ADDR_MAP_CRC    = 4'hf;
    // ****************************************
    // status field positions
    // ****************************************
    localparam int BIT_NEW_SAMPLE = 0;
    localparam int BIT_MOD_SAT    = 1;
    localparam int BIT_ADC_FAULT  = 2;
    localparam int BIT_MAP_CRC    = 3;
    localparam int BIT_LINK_CRC   = 4;
    // ****************************************
    // fourth setup register fields and reset
    // ****************************************
    localparam int BIT_MAP_CHK_EN  = 1;
    localparam int BIT_LINK_CHK_EN = 2;
    localparam logic [7:0] SETUP4_RESET = 8'h08;
    localparam logic [7:0] CRC_RESET    = 8'h00;
endpackage

// ---- asef_status_flags.sv ----
// status error flag bank behind the serial register port
//
// Overview of operation
// - link crc error sets status bit 4
// - write one clears link fault unless enabled error same cycle
// - link check only when enable set
// - map crc mismatch sets status bit 3
// - map fault clears by w1c unless enabled mismatch same cycle, or by disable
// - map compare only while enabled
// - converter fault read-only, reset clears
// - saturation bit refreshed per conversion
// - new-data bit inverts data-ready pin
// - new-data one when fresh, else zero
// - one-shot keeps new-data until start
// - status register at address 2h
`timescale 1ns/1ps
module asef_status_flags
    import asef_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_wr_taken_o,
    input  wire logic       frame_crc_err_i,
    input  wire logic [7:0] map_crc_calc_i,
    input  wire logic       adc_fault_i,
    input  wire logic       conv_done_i,
    input  wire logic       mod_sat_i,
    input  wire logic       conv_start_i,
    input  wire logic       one_shot_i,
    input  wire logic       result_read_i,
    input  wire logic [2:0] upper_status_i,
    output logic      [7:0] setup4_o,
    output logic            data_ready_n_o
);
    logic       link_err_reg, link_err_next;
    logic       map_err_reg, map_err_next;
    logic       adc_err_reg, adc_err_next;
    logic       mod_sat_reg, mod_sat_next;
    logic [7:0] setup4_reg, setup4_next;
    logic [7:0] crc_reg, crc_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       wr_ok;
    logic       st_wr;
    logic [7:0] status_view;

    // ****************************************
    // write gating
    // ****************************************
    // status decode at 2h
    assign st_wr = reg_wr_i && (reg_addr_i == ADDR_STATUS);
    assign wr_ok = reg_wr_i && (!link_err_reg || st_wr);
    assign reg_wr_taken_o = wr_ok;

    // ****************************************
    // flag and register next state
    // ****************************************
    always_comb begin
        setup4_next   = setup4_reg;
        crc_next      = crc_reg;
        link_err_next = link_err_reg;
        map_err_next  = map_err_reg;
        mod_sat_next  = mod_sat_reg;
        adc_err_next  = adc_err_reg | adc_fault_i;
        if (wr_ok && reg_addr_i == ADDR_SETUP4) begin
            setup4_next = reg_wdata_i;
        end else if (wr_ok && reg_addr_i == ADDR_MAP_CRC) begin
            crc_next = reg_wdata_i;
        end
        if (st_wr && reg_wdata_i[BIT_LINK_CRC]) begin
            link_err_next = 1'b0;
        end
        if (frame_crc_err_i && setup4_reg[BIT_LINK_CHK_EN]) begin
            link_err_next = 1'b1;
        end
        // clear by write one or disable
        if ((st_wr && reg_wdata_i[BIT_MAP_CRC])
            || !setup4_next[BIT_MAP_CHK_EN]) begin
            map_err_next = 1'b0;
        end
        if (setup4_reg[BIT_MAP_CHK_EN] && setup4_next[BIT_MAP_CHK_EN]
            && crc_reg != map_crc_calc_i) begin
            map_err_next = 1'b1;
        end
        if (conv_done_i) begin
            mod_sat_next = mod_sat_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            setup4_reg   <= SETUP4_RESET;
            crc_reg      <= CRC_RESET;
            link_err_reg <= 1'b0;
            map_err_reg  <= 1'b0;
            adc_err_reg  <= 1'b0;
            mod_sat_reg  <= 1'b0;
            rdata_reg    <= 8'h00;
        end else begin
            setup4_reg   <= setup4_next;
            crc_reg      <= crc_next;
            link_err_reg <= link_err_next;
            map_err_reg  <= map_err_next;
            adc_err_reg  <= adc_err_next;
            mod_sat_reg  <= mod_sat_next;
            rdata_reg    <= rdata_next;
        end
    end

    // ****************************************
    // new-sample tracking
    // ****************************************
    asef_new_sample u_new_sample (
        .ref_clk_i      (ref_clk_i),
        .reset_i        (reset_i),
        .conv_done_i    (conv_done_i),
        .conv_start_i   (conv_start_i),
        .one_shot_i     (one_shot_i),
        .result_read_i  (result_read_i),
        .data_ready_n_o (data_ready_n_o)
    );

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        status_view = {upper_status_i, link_err_reg, map_err_reg,
                       adc_err_reg, mod_sat_reg, 1'b0};
        status_view[BIT_NEW_SAMPLE] = ~data_ready_n_o;
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            if (reg_addr_i == ADDR_STATUS) begin
                rdata_next = status_view;
            end else if (reg_addr_i == ADDR_SETUP4) begin
                rdata_next = setup4_reg;
            end else if (reg_addr_i == ADDR_MAP_CRC) begin
                rdata_next = crc_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign setup4_o    = setup4_reg;

    // ****************************************
    // checks
    // ****************************************
    // blocked write leaves setup intact
    block_setup_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        link_err_reg && reg_wr_i && reg_addr_i == ADDR_SETUP4
        |=> $stable(setup4_reg))
        else $error("setup write taken during link fault");
    link_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        frame_crc_err_i && setup4_reg[BIT_LINK_CHK_EN] |=> link_err_reg)
        else $error("link fault flag not set");
    link_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !link_err_reg && !(frame_crc_err_i && setup4_reg[BIT_LINK_CHK_EN])
        |=> !link_err_reg)
        else $error("link fault set without enabled error");
    link_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        st_wr && reg_wdata_i[BIT_LINK_CRC] && !frame_crc_err_i
        |=> !link_err_reg)
        else $error("link fault not cleared");
    map_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !setup4_reg[BIT_MAP_CHK_EN] |-> !map_err_reg)
        else $error("map fault set while check disabled");
    map_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        setup4_reg[BIT_MAP_CHK_EN] && setup4_next[BIT_MAP_CHK_EN]
        && crc_reg != map_crc_calc_i |=> map_err_reg)
        else $error("map fault not set on mismatch");
    adc_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        adc_err_reg |=> adc_err_reg)
        else $error("converter fault cleared without reset");
    sat_track_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        conv_done_i |=> mod_sat_reg == $past(mod_sat_i))
        else $error("saturation bit not refreshed");
    ready_mirror_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == ADDR_STATUS
        |=> reg_rdata_o[BIT_NEW_SAMPLE] == $past(~data_ready_n_o))
        else $error("new-data bit not inverse of pin");
    wr_refuse_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        link_err_reg && reg_wr_i && reg_addr_i != ADDR_STATUS
        |-> !reg_wr_taken_o)
        else $error("write accepted during link fault");
    st_accept_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        reg_wr_i && reg_addr_i == ADDR_STATUS |-> reg_wr_taken_o)
        else $error("status write refused");
    map_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !map_err_reg && !setup4_reg[BIT_MAP_CHK_EN] |=> !map_err_reg)
        else $error("map fault set while compare disabled");
    map_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        st_wr && reg_wdata_i[BIT_MAP_CRC] && crc_reg == map_crc_calc_i
        |=> !map_err_reg)
        else $error("map fault not cleared by write one");
    sat_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !conv_done_i |=> $stable(mod_sat_reg))
        else $error("saturation bit changed without conversion");
    st_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == ADDR_STATUS
        |=> reg_rdata_o[BIT_LINK_CRC] == $past(link_err_reg))
        else $error("status read lost link flag");
endmodule // asef_status_flags

// ---- testbench.sv ----
// self-checking bench for the status error flag bank
`timescale 1ns/1ps
module testbench;
    import asef_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic [4:0] ev_v      = 5'h00;
    logic       mod_sat   = 1'b0;
    logic       one_shot  = 1'b0;
    logic       wr, rd, wr_taken, dr_n, tk;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, setup4, got;
    int         fail_count = 0;
    int         cmp_count  = 0;
    // ****************************************
    // clock, design and host
    // ****************************************
    always #25 ref_clk_i = ~ref_clk_i;
    asef_status_flags DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_wr_taken_o(wr_taken), .frame_crc_err_i(ev_v[0]),
        .map_crc_calc_i(8'h5a), .adc_fault_i(ev_v[4]),
        .conv_done_i(ev_v[1]), .mod_sat_i(mod_sat),
        .conv_start_i(ev_v[2]), .one_shot_i(one_shot),
        .result_read_i(ev_v[3]), .upper_status_i(3'h5),
        .setup4_o(setup4), .data_ready_n_o(dr_n));
    asef_host_model host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
        .reg_wr_taken_i(wr_taken), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));
    // ****************************************
    // helper tasks
    // ****************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic st(input logic [7:0] e);
        host.rd(ADDR_STATUS, got);
        chk(got, e);
    endtask
    // one-cycle pulse on the event inputs, then let it settle
    task automatic ev(input logic [4:0] e);
        @(posedge ref_clk_i) ev_v <= e;
        @(posedge ref_clk_i) ev_v <= 5'h00;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic do_reset;
        @(posedge ref_clk_i) reset_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        fail_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        test_done;
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        st(8'ha0);
        host.rd(ADDR_SETUP4, got);
        chk(got, SETUP4_RESET);
        host.rd(4'h3, got);
        chk(got, 8'h00);
        $display("test reset values done");
        ev(5'h01);
        st(8'ha0);
        host.wr(ADDR_SETUP4, 8'h0c, tk);
        ev(5'h01);
        st(8'hb0);
        host.wr(ADDR_SETUP4, 8'h0e, tk);
        chk({7'h00, tk}, 8'h00);
        chk(setup4, 8'h0c);
        host.wr(ADDR_STATUS, 8'h10, tk);
        chk({7'h00, tk}, 8'h01);
        st(8'ha0);
        $display("test link flag done");
        host.wr(ADDR_SETUP4, 8'h0a, tk);
        st(8'ha8);
        host.wr(ADDR_MAP_CRC, 8'h5a, tk);
        host.wr(ADDR_STATUS, 8'h08, tk);
        st(8'ha0);
        host.wr(ADDR_MAP_CRC, 8'h00, tk);
        st(8'ha8);
        host.wr(ADDR_SETUP4, 8'h08, tk);
        st(8'ha0);
        $display("test map flag done");
        @(posedge ref_clk_i) mod_sat <= 1'b1;
        ev(5'h02);
        st(8'ha3);
        chk({7'h00, dr_n}, 8'h00);
        ev(5'h08);
        st(8'ha2);
        @(posedge ref_clk_i) mod_sat <= 1'b0;
        ev(5'h02);
        st(8'ha1);
        ev(5'h08);
        @(posedge ref_clk_i) one_shot <= 1'b1;
        ev(5'h02);
        ev(5'h08);
        st(8'ha1);
        ev(5'h04);
        st(8'ha0);
        $display("test new data done");
        ev(5'h10);
        host.wr(ADDR_STATUS, 8'h04, tk);
        st(8'ha4);
        do_reset;
        st(8'ha0);
        $display("test converter fault done");
        test_done;
    end
endmodule // testbench
